// [bench/tap_ctrl_model.sv]
// external boundary-scan controller model: test clock, serial data, strobes
`timescale 1ns/1ns
`default_nettype none

module tap_ctrl_model (
  // test clock and serial data
  output var  logic tck,
  output var  logic tdi,
  input  wire logic tdo,
  // tap state strobes, one at a time
  output wire logic test_logic_reset,
  output wire logic capture_ir,
  output wire logic shift_ir,
  output wire logic update_ir,
  output wire logic capture_dr,
  output wire logic shift_dr,
  output wire logic update_dr
);
  logic [6:0] st;

  assign {test_logic_reset, capture_ir, shift_ir, update_ir,
          capture_dr, shift_dr, update_dr} = st;

  // tck stands high between frames; tdi idles high like its pull-up
  initial begin
    tck = 1'b1;
    tdi = 1'b1;
    st  = 7'h00;
  end

  // one state: strobes change just after a rise, tdo taken at the next rise
  task automatic step(input logic [6:0] s, input logic d, output logic q);
    #1;
    st  = s;
    tdi = d;
    #2 tck = 1'b0;
    #3;
    q   = tdo;
    tck = 1'b1;
  endtask

  // capture, shift lsb first, optional update, then idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      input logic upd, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(ir ? 7'h20 : 7'h04, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(ir ? 7'h10 : 7'h02, din[i], q);
      dout[i] = q;
    end
    if (upd) step(ir ? 7'h08 : 7'h01, 1'b1, q);
    step(7'h00, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// [bench/test_jtag_instruction_decode.sv]
// self-checking bench for the boundary-scan instruction decoder
`include "jtag_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module test_jtag_instruction_decode;
  import jtag_pkg::*;

  typedef struct packed {
    logic [4:0] code;
    instr_t     ins;
    logic       iso;
    logic [3:0] sel;
    logic [1:0] path;
  } row_t;

  logic        sys_clk, rst_b, cke, core_isolated, tck, trst_b, tdi;
  logic        tdo, tdo_oe, dbg_tdo, test_logic_reset, capture_ir;
  logic        shift_ir, update_ir, capture_dr, shift_dr, update_dr;
  logic [3:0]  dbg_sel, core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  wire         tdo_w;
  instr_t      instr;
  logic [31:0] dout;
  int          n_fail, checks_done;

  // path: 0 bypass, 1 identification, 2 debug return, 3 not scanned here
  row_t rows [15] = '{
    '{5'h00, I_EXTEST, 1'b1, 4'h0, 2'd3}, '{5'h01, I_SAMPLE, 1'b0, 4'h0, 2'd3},
    '{5'h1F, I_BYPASS, 1'b0, 4'h0, 2'd0}, '{5'h1E, I_IDCODE, 1'b0, 4'h0, 2'd1},
    '{5'h04, I_CLAMP, 1'b1, 4'h0, 2'd0}, '{5'h08, I_HIGHZ, 1'b1, 4'h0, 2'd0},
    '{5'h02, I_DBGRX, 1'b0, 4'h1, 2'd2}, '{5'h07, I_LDIC, 1'b0, 4'h2, 2'd2},
    '{5'h09, I_DCSR, 1'b0, 4'h4, 2'd2}, '{5'h10, I_DBGTX, 1'b0, 4'h8, 2'd2},
    '{5'h03, I_BYPASS, 1'b0, 4'h0, 2'd0}, '{5'h0E, I_BYPASS, 1'b0, 4'h0, 2'd0},
    '{5'h19, I_BYPASS, 1'b0, 4'h0, 2'd0}, '{5'h1D, I_BYPASS, 1'b0, 4'h0, 2'd0},
    '{5'h06, I_BYPASS, 1'b0, 4'h0, 2'd0}
  };

  // released tdo shows the inverse, so a read outside a shift state fails
  assign tdo_w = tdo_oe ? tdo : ~tdo;

  jtag_instruction_decode jtag_instruction_decode_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cke(cke),
    .core_isolated(core_isolated), .tck(tck), .trst_b(trst_b), .tdi(tdi),
    .test_logic_reset(test_logic_reset), .capture_ir(capture_ir),
    .shift_ir(shift_ir), .update_ir(update_ir), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr), .tdo(tdo), .tdo_oe(tdo_oe),
    .instr(instr), .dbg_sel(dbg_sel), .dbg_tdo(dbg_tdo),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

  tap_ctrl_model tap_ctrl_model_i (
    .tck(tck), .tdi(tdi), .tdo(tdo_w), .test_logic_reset(test_logic_reset),
    .capture_ir(capture_ir), .shift_ir(shift_ir), .update_ir(update_ir),
    .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr));

  always #5 sys_clk = ~sys_clk;

  // compare and count; an unknown never matches
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // load an instruction, then give the system side time to follow
  task automatic load_ir(input logic [4:0] code);
    tap_ctrl_model_i.scan(1'b1, {27'h0, code}, 5, 1'b1, dout);
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  task automatic scan_dr(input logic [31:0] din, input int n, input logic upd);
    tap_ctrl_model_i.scan(1'b0, din, n, upd, dout);
  endtask

  // hang guard, far beyond the few microseconds the run needs
  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin : main
    row_t        r;
    logic [31:0] exp;
    sys_clk  = 1'b0;
    rst_b    = 1'b0;
    trst_b   = 1'b0;
    cke      = 1'b1;
    dbg_tdo  = 1'b1;
    core_out = 4'h5;
    core_oe  = 4'hA;
    pad_in   = 4'h6;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b  = 1'b1;
    trst_b = 1'b1;
    // table: decode, selects, isolation, pads and serial path
    foreach (rows[i]) begin
      r = rows[i];
      load_ir(r.code);
      check("instr", instr, r.ins);
      check("dbg_sel", dbg_sel, r.sel);
      check("isolated", core_isolated, r.iso);
      check("pad_oe", pad_oe, r.iso ? 4'h0 : core_oe);
      if (r.ins != I_HIGHZ) check("pad_out", pad_out, r.iso ? 4'h0 : core_out);
      if (r.path != 2'd3) begin
        scan_dr(32'hB, 4, 1'b0);
        exp = (r.path == 2'd1) ? (`ID_VALUE & 32'hF) : 32'hF;
        if (r.path == 2'd0) exp = 32'h6;
        check("dr path", dout, exp);
      end
      $display("row %0d code %h done", i, r.code);
    end
    // reset: idcode selected, system mode, capture pattern and id shifted out
    trst_b = 1'b0;
    #20;
    check("instr rst", instr, I_IDCODE);
    check("pad_oe rst", pad_oe, core_oe);
    trst_b = 1'b1;
    tap_ctrl_model_i.scan(1'b1, 32'h1E, 5, 1'b1, dout);
    check("ir capture", dout, `IR_CAPTURE);
    scan_dr(32'h0, 32, 1'b0);
    check("idcode", dout, `ID_VALUE);
    $display("reset test done");
    // preload guard values under sample; pads stay with the core
    load_ir(5'h01);
    scan_dr(32'h3C0, 12, 1'b1);
    check("sample", dout[11:4], {core_oe, core_out});
    check("preload oe", pad_oe, core_oe);
    check("preload out", pad_out, core_out);
    // extest: pads from update stage, change only at update
    load_ir(5'h00);
    check("ext pads", {pad_oe, pad_out}, 8'h3C);
    check("ext iso", core_isolated, 1'b1);
    scan_dr(32'h5A0, 12, 1'b0);
    check("ext capture", dout[3:0], pad_in);
    check("tdo float", tdo_oe, 1'b0);
    check("core_in", core_in, pad_in);
    check("ext hold", {pad_oe, pad_out}, 8'h3C);
    scan_dr(32'h5A0, 12, 1'b1);
    check("ext update", {pad_oe, pad_out}, 8'h5A);
    $display("sample and extest test done");
    // clamp: pads frozen through an update, bypass on the serial path
    load_ir(5'h04);
    scan_dr(32'hB, 4, 1'b1);
    check("clamp path", dout, 32'h6);
    check("clamp pads", {pad_oe, pad_out}, 8'h5A);
    // test reset in mid-run drops straight back to idcode
    #7 trst_b = 1'b0;
    #1;
    check("trst instr", instr, I_IDCODE);
    check("trst pads", pad_oe, core_oe);
    #9 trst_b = 1'b1;
    $display("clamp and test reset test done");
    // the logic-reset state selects idcode as well
    load_ir(5'h1F);
    tap_ctrl_model_i.step(7'h40, 1'b1, dout[0]);
    tap_ctrl_model_i.step(7'h00, 1'b1, dout[0]);
    check("tlr instr", instr, I_IDCODE);
    $display("logic reset test done");
    // cke low freezes the isolation level seen by the core
    @(posedge sys_clk);
    #1;
    cke = 1'b0;
    load_ir(5'h08);
    check("iso frozen", core_isolated, 1'b0);
    check("highz oe", pad_oe, 4'h0);
    cke = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check("iso highz", core_isolated, 1'b1);
    $display("clock enable test done");
    test_done();
  end
endmodule
`default_nettype wire

// [hw/jtag_cfg.svh]
// constants for the boundary-scan instruction decoder
`ifndef JTAG_CFG_SVH
`define JTAG_CFG_SVH

// instruction register
`define IR_LEN      5
`define IR_CAPTURE  5'h01
// mandatory public codes
`define OP_EXTEST   5'h00
`define OP_SAMPLE   5'h01
`define OP_BYPASS   5'h1F
// optional public codes
`define OP_IDCODE   5'h1E
`define OP_CLAMP    5'h04
`define OP_HIGHZ    5'h08
// vendor debug codes
`define OP_DBGRX    5'h02
`define OP_LDIC     5'h07
`define OP_DCSR     5'h09
`define OP_DBGTX    5'h10

// identification register, value arbitrary and neutral
`define ID_LEN      32
`define ID_VALUE    32'h0C0D_E001

// boundary cells: inputs, then output data, then output enables
`define N_IN        4
`define N_OUT       4
`define BSR_LEN     12
`define DBG_CNT     4

`endif

// [hw/jtag_instruction_decode.sv]
// boundary-scan instruction decode, data registers and pin isolation
`include "jtag_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module jtag_instruction_decode (
  // system clock domain
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  cke,
  output var  logic                  core_isolated,
  // test clock and tap state strobes
  input  wire logic                  tck,
  input  wire logic                  trst_b,
  input  wire logic                  tdi,
  input  wire logic                  test_logic_reset,
  input  wire logic                  capture_ir,
  input  wire logic                  shift_ir,
  input  wire logic                  update_ir,
  input  wire logic                  capture_dr,
  input  wire logic                  shift_dr,
  input  wire logic                  update_dr,
  // serial output
  output var  logic                  tdo,
  output var  logic                  tdo_oe,
  // decoded instruction
  output var  jtag_pkg::instr_t      instr,
  // debug data register selects and their serial return
  output var  logic [`DBG_CNT-1:0]   dbg_sel,
  input  wire logic                  dbg_tdo,
  // core side of the pads
  input  wire logic [`N_OUT-1:0]     core_out,
  input  wire logic [`N_OUT-1:0]     core_oe,
  output var  logic [`N_IN-1:0]      core_in,
  // pads
  input  wire logic [`N_IN-1:0]      pad_in,
  output var  logic [`N_OUT-1:0]     pad_out,
  output var  logic [`N_OUT-1:0]     pad_oe
);
  import jtag_pkg::*;

  localparam int NI = `N_IN;
  localparam int NO = `N_OUT;
  localparam int BL = `BSR_LEN;

  logic [`IR_LEN-1:0]  ir_sr;
  instr_t              instr_reg;
  logic                bypass_reg;
  logic [`ID_LEN-1:0]  id_sr;
  logic [BL-1:0]       bsr;
  logic [2*NO-1:0]     upd_reg;
  logic [NI-1:0]       pad_in_s;
  logic [2*NO-1:0]     core_s;
  logic                serial_bit;
  logic                pin_drive;
  logic                iso_s;
  logic                tdo_reg;
  logic                tdo_oe_reg;

  // code to instruction; anything without its own function is bypass
  function automatic instr_t decode(input logic [`IR_LEN-1:0] code);
    instr_t r;
    r = I_BYPASS;
    case (code)
      `OP_EXTEST: r = I_EXTEST;
      `OP_SAMPLE: r = I_SAMPLE;
      `OP_BYPASS: r = I_BYPASS;
      `OP_IDCODE: r = I_IDCODE;
      `OP_CLAMP:  r = I_CLAMP;
      `OP_HIGHZ:  r = I_HIGHZ;
      `OP_DBGRX:  r = I_DBGRX;
      `OP_LDIC:   r = I_LDIC;
      `OP_DCSR:   r = I_DCSR;
      `OP_DBGTX:  r = I_DBGTX;
      // private and unused codes, no own path
      // no code maps to runbist, intest or usercode
      // they fall back to bypass in system mode
      default:    r = I_BYPASS;
    endcase
    return r;
  endfunction

  // pins are outside the test clock domain
  sync2 #(.W(NI)) pin_sync (
    .clk    (tck),
    .arst_b (trst_b),
    .en     (1'b1),
    .d      (pad_in),
    .q      (pad_in_s)
  );

  // core outputs come from the system clock domain
  sync2 #(.W(2*NO)) core_sync (
    .clk    (tck),
    .arst_b (trst_b),
    .en     (1'b1),
    .d      ({core_oe, core_out}),
    .q      (core_s)
  );

  // instruction shift stage, captures fixed pattern in Capture-IR
  // msb takes tdi, lsb leaves towards tdo
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      ir_sr <= `IR_CAPTURE;
    end else if (capture_ir) begin
      ir_sr <= `IR_CAPTURE;
    end else if (shift_ir) begin
      ir_sr <= {tdi, ir_sr[`IR_LEN-1:1]};
    end
  end

  // latched instruction changes on falling edge only
  // reset forces idcode without a clock
  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      instr_reg <= I_IDCODE;
    end else if (test_logic_reset) begin
      instr_reg <= I_IDCODE;
    end else if (update_ir) begin
      instr_reg <= decode(ir_sr);
    end
  end

  assign instr = instr_reg;

  // bypass bit loads zero in Capture-DR, one-cycle delay in Shift-DR
  // bypass path for clamp, highz and bypass
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      bypass_reg <= 1'b0;
    end else if (capture_dr) begin
      bypass_reg <= 1'b0;
    end else if (shift_dr) begin
      bypass_reg <= tdi;
    end
  end

  // identification register; shifted-in data is discarded
  // fixed code loaded in Capture-DR
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      id_sr <= `ID_VALUE;
    end else if (instr_reg == I_IDCODE) begin
      if (capture_dr) begin
        id_sr <= `ID_VALUE;
      end else if (shift_dr) begin
        id_sr <= {1'b0, id_sr[`ID_LEN-1:1]};
      end
    end
  end

  // boundary shift stage; only touched under extest and sample
  // input cells take the pins under extest
  // output cells take core values under sample
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      bsr <= '0;
    end else if (instr_reg == I_EXTEST || instr_reg == I_SAMPLE) begin
      if (capture_dr) begin
        bsr <= {core_s, pad_in_s};
      end else if (shift_dr) begin
        bsr <= {tdi, bsr[BL-1:1]};
      end
    end
  end

  // update stage, written on falling edge in Update-DR
  // preload copies shift stage without driving pins
  // clamp never writes it, so pins hold still
  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      upd_reg <= '0;
    end else if (update_dr &&
                 (instr_reg == I_EXTEST || instr_reg == I_SAMPLE)) begin
      upd_reg <= bsr[BL-1:NI];
    end
  end

  // serial source per instruction
  // boundary register only for extest and sample
  always_comb begin
    case (instr_reg)
      I_EXTEST, I_SAMPLE:          serial_bit = bsr[0];
      I_IDCODE:                    serial_bit = id_sr[0];
      I_DBGRX, I_LDIC,
      I_DCSR, I_DBGTX:             serial_bit = dbg_tdo;
      default:                     serial_bit = bypass_reg;
    endcase
  end

  // debug data registers live outside; tell them who is selected
  // one select per debug instruction
  assign dbg_sel = {instr_reg == I_DBGTX, instr_reg == I_DCSR,
                    instr_reg == I_LDIC,  instr_reg == I_DBGRX};

  // tdo changes on falling edge, floats outside shift states
  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= shift_ir ? ir_sr[0] : serial_bit;
      tdo_oe_reg <= shift_ir | shift_dr;
    end
  end

  assign tdo    = tdo_reg;
  assign tdo_oe = tdo_oe_reg;

  // strobes hold from one rise to the next, so the level set on the
  // falling edge must match the shift strobes seen at the next rise
  tdo_float_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    tdo_oe == (shift_ir || shift_dr))
    else $error("tdo driven outside a shift state");

  // pad multiplexer; sample and bypass leave pins in system mode
  // extest and clamp drive pins from update stage
  assign pin_drive = (instr_reg == I_EXTEST) || (instr_reg == I_CLAMP);

  always_comb begin
    if (instr_reg == I_HIGHZ) begin
      pad_out = core_out;
      pad_oe  = '0;
    end else if (pin_drive) begin
      pad_out = upd_reg[NO-1:0];
      pad_oe  = upd_reg[2*NO-1:NO];
    end else begin
      pad_out = core_out;
      pad_oe  = core_oe;
    end
  end

  // core sees the pads directly, never the input cells
  // input cells have no path into the core
  assign core_in = pad_in;

  // isolation level handed to the core clock domain
  sync2 #(.W(1)) iso_sync (
    .clk    (sys_clk),
    .arst_b (rst_b),
    .en     (cke),
    .d      (pin_drive | (instr_reg == I_HIGHZ)),
    .q      (iso_s)
  );

  // registered so the core sees a clean level, frozen with cke
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_isolated <= 1'b0;
    end else if (cke) begin
      core_isolated <= iso_s;
    end
  end

  // checks on the test clock domain

  ir_msb_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    shift_ir && !capture_ir |=> ir_sr[`IR_LEN-1] == $past(tdi))
    else $error("ir msb did not take tdi");

  reset_idcode_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    test_logic_reset |=> instr_reg == I_IDCODE)
    else $error("reset did not select idcode");

  id_capture_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    capture_dr && instr_reg == I_IDCODE |=> id_sr == `ID_VALUE)
    else $error("id code not loaded");

  bypass_cap_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    capture_dr ##1 shift_dr |=> bypass_reg == $past(tdi))
    else $error("bypass bit not shifted");

  extest_cap_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    capture_dr && instr_reg == I_EXTEST
    |=> bsr[NI-1:0] == $past(pad_in_s))
    else $error("input pins not captured");

  sample_cap_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    capture_dr && instr_reg == I_SAMPLE
    |=> bsr[BL-1:NI] == $past(core_s))
    else $error("core outputs not sampled");

  clamp_hold_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    instr_reg == I_CLAMP && $past(instr_reg) == I_CLAMP
    |-> $stable(pad_out) && $stable(pad_oe))
    else $error("pins moved under clamp");

  extest_pin_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    instr_reg == I_EXTEST |-> pad_out == upd_reg[NO-1:0])
    else $error("extest pins not from update stage");

  highz_float_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    instr_reg == I_HIGHZ |-> pad_oe == '0 && serial_bit == bypass_reg)
    else $error("highz left a pin driven");

  unused_byp_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    update_ir && ir_sr == 5'h06 |=> instr_reg == I_BYPASS
    && pad_oe == core_oe)
    else $error("unused code not bypass");

  preload_a: assert property (
    @(posedge tck) disable iff (!trst_b)
    update_dr && instr_reg == I_SAMPLE
    |=> upd_reg == $past(bsr[BL-1:NI]) && pad_out == core_out)
    else $error("preload failed or drove pins");

endmodule

`default_nettype wire

// [hw/jtag_pkg.sv]
// types shared by the boundary-scan instruction decoder
package jtag_pkg;

  // decoded current instruction
  typedef enum logic [3:0] {
    I_EXTEST,
    I_SAMPLE,
    I_CLAMP,
    I_HIGHZ,
    I_IDCODE,
    I_BYPASS,
    I_DBGRX,
    I_LDIC,
    I_DCSR,
    I_DBGTX
  } instr_t;

endpackage

// [hw/sync2.sv]
// two-flop level synchroniser with enable
`timescale 1ns/1ns
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_b,
  input  wire logic         en,
  // level in and out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_b) begin
    if (!arst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (en) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire
